// ==== hw/gdtr_pkg.sv ====
// Purpose: Shared constants and types for the diagnostic, id and trim register bank
// Assumes: 25 MHz core clock, host frames of 32 bits on a four-wire serial port
// Notes: Addresses are byte addresses; reads return the addressed byte and the next one, an even/odd pair for an even address
package gdtr_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ST_UPDATE_HZ = 1000;
  localparam int QUAD_UPDATE_HZ = 250;
  localparam int ST_TICK_CYC = CLK_HZ / ST_UPDATE_HZ;
  localparam int QUAD_TICK_CYC = CLK_HZ / QUAD_UPDATE_HZ;
  localparam int FAULT_SET_US = 5;
  localparam int FAULT_SET_CYC = (FAULT_SET_US * 1000) / CLK_PERIOD_NS;
  // One-pole filters at the 1 kHz update rate
  localparam int ST_LPF_SHIFT = 6;
  localparam int QUAD_LPF_SHIFT = 1;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [5:0] ADDR_RAW_ST_HI = 6'h06;
  localparam logic [5:0] ADDR_RAW_ST_LO = 6'h07;
  localparam logic [5:0] ADDR_QUAD_HI = 6'h08;
  localparam logic [5:0] ADDR_QUAD_LO = 6'h09;
  localparam logic [5:0] ADDR_FAULT_HI = 6'h0a;
  localparam logic [5:0] ADDR_FAULT_LO = 6'h0b;
  localparam logic [5:0] ADDR_PART_HI = 6'h0c;
  localparam logic [5:0] ADDR_PART_LO = 6'h0d;
  localparam logic [5:0] ADDR_SERIAL_3 = 6'h0e;
  localparam logic [5:0] ADDR_SERIAL_2 = 6'h0f;
  localparam logic [5:0] ADDR_SERIAL_1 = 6'h10;
  localparam logic [5:0] ADDR_SERIAL_0 = 6'h11;
  localparam logic [5:0] ADDR_TRIM_HI = 6'h12;
  localparam logic [5:0] ADDR_TRIM_LO = 6'h13;

  localparam logic [9:0] TRIM_RST = 10'h000;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [15:0] FAULT_RST = 16'h0000;
  localparam logic signed [15:0] ST_LIMIT_LO = 16'shfce0;
  localparam logic signed [15:0] ST_LIMIT_HI = 16'sh0320;

  // ************************************************************
  // Host frame
  // ************************************************************
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_SENSOR = 2'h3;
  localparam logic [5:0] CMD_LAST_BIT = 6'h07;
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam int WDATA_LSB = 8;
  localparam int TRIM_BITS = 10;

  typedef struct packed {
    logic [1:0] op;
    logic [5:0] addr;
  } gdtr_cmd_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } gdtr_pins_t;

  typedef struct packed {
    logic fail;
    logic drive_level_fault;
    logic supply_high_fault;
    logic supply_low_fault;
    logic pll_fault;
    logic q_fault;
    logic stored_memory_fault;
    logic por_fault;
    logic supply_fault;
    logic self_check_fault;
  } gdtr_fault_in_t;

endpackage

// ==== hw/gdtr_tick.sv ====
// Purpose: Divider giving a one-cycle enable every DIV clocks
// Assumes: DIV of two or more
// Notes: First pulse DIV cycles after reset release
module gdtr_tick #(
  parameter int unsigned DIV = 25000
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  output logic tick_o
);

  logic [31:0] cnt_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_reg == 32'(DIV - 1)) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick_o <= 1'b0;
    end
  end

endmodule // gdtr_tick

// ==== hw/gdtr_lpf.sv ====
// Purpose: One-pole low-pass filter on a signed 16-bit sample stream
// Assumes: en_i is a one-cycle sample strobe
// Notes: Eight fraction bits keep small steps from stalling the output
module gdtr_lpf #(
  parameter int unsigned SHIFT = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  input wire logic [15:0] din_i,
  output logic [15:0] dout_o
);

  logic signed [23:0] acc_reg;
  logic signed [24:0] diff;
  logic signed [24:0] step;
  logic signed [23:0] acc_next;

  // Step toward the input, so the sum never leaves 24 bits
  assign diff = $signed({din_i[15], din_i, 8'h00}) - $signed({acc_reg[23], acc_reg});
  assign step = diff >>> SHIFT;
  assign acc_next = 24'(acc_reg + step[23:0]);
  assign dout_o = acc_reg[23:8];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_reg <= 24'h0;
    end else if (en_i) begin
      acc_reg <= acc_next;
    end
  end

endmodule // gdtr_lpf

// ==== hw/gdtr_regs.sv ====
// Purpose: Diagnostic, part id, serial and null-trim register bank behind the host serial port
// Assumes: Serial clock idles low, data sampled on its rising edge and driven after its falling edge
// Notes: Frame is 8 command bits then 24 data bits; answers come in the same frame
//
// Functional notes
// - The raw self-test value is refreshed at 1000 Hz with no filtering, 16-bit signed at 80 LSB per deg/s.
// - The raw self-test value never sets the self-test fault flag on its own.
// - The self-test fault flag follows only the filtered self-test value against its limits.
// - The quadrature-error value is refreshed at 250 Hz after an 80 Hz low-pass, 16-bit signed.
// - Every sensor data answer ends with the low fault byte, which is also readable at its own address.
// - Each fault flag is set as soon as its condition exists, regardless of transfers, within 5 us.
// - A set fault flag holds until the fault register is read or a sensor data command arrives.
// - A flag whose condition persists stays set through that clear, since the condition wins in the same cycle.
// - The high fault byte carries failure, drive level, supply high and supply low in its low four bits.
// - The part version is a read-only 16-bit code that later silicon raises by one.
// - Only the null-trim register takes host writes; everything else is read-only.
// - The signed 10-bit null trim, 80 LSB per deg/s, is added to the static rate output.
// - Reads go to even addresses and return the addressed byte then the next byte, MSB first.
// - The self-test delta is filtered to 2.5 Hz before the limit compare.
module gdtr_regs
  import gdtr_pkg::*;
#(
  parameter int unsigned ST_TICK_DIV = ST_TICK_CYC,
  parameter int unsigned QUAD_TICK_DIV = QUAD_TICK_CYC,
  // Arbitrary value; later silicon adds one
  parameter logic [15:0] PART_VERSION = 16'h0a01,
  // Arbitrary value
  parameter logic [31:0] SERIAL_NUMBER = 32'h1234_5678
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic [15:0] rate_i,
  input wire logic [15:0] raw_selftest_i,
  input wire logic [15:0] quad_error_i,
  input wire gdtr_fault_in_t fault_cond_i,
  output logic [15:0] rate_trimmed_o,
  output logic [15:0] fault_flags_o
);

  // ************************************************************
  // Declarations
  // ************************************************************
  typedef enum logic [1:0] {
    FR_IDLE,
    FR_CMD,
    FR_DATA
  } gdtr_frame_t;

  gdtr_frame_t frame_reg;
  gdtr_frame_t frame_next;
  gdtr_pins_t pin_s1_reg;
  gdtr_pins_t pin_s2_reg;
  gdtr_pins_t pin_prev_reg;
  gdtr_fault_in_t fault_s1_reg;
  gdtr_fault_in_t fault_s2_reg;
  gdtr_cmd_t cmd_word;

  logic [5:0] bit_cnt_reg;
  logic [31:0] shift_in_reg;
  logic [23:0] resp_reg;
  logic [23:0] resp_next;
  logic miso_reg;
  logic miso_oe_reg;
  logic [15:0] raw_st_reg;
  logic [15:0] quad_reg;
  logic [15:0] flags_reg;
  logic [15:0] flags_next;
  logic [15:0] rate_trim_reg;
  logic [9:0] trim_reg;

  logic st_tick;
  logic quad_tick;
  logic [15:0] st_filt;
  logic [15:0] quad_filt;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic frame_start;
  logic frame_end;
  logic cmd_done;
  logic fault_clear;
  logic st_fault;
  logic [15:0] cond_vec;
  logic [15:0] read_pair;
  logic trim_write;

  // ************************************************************
  // Update rates and filters
  // ************************************************************
  gdtr_tick #(
    .DIV(ST_TICK_DIV)
  ) u_st_tick (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tick_o(st_tick)
  );

  gdtr_tick #(
    .DIV(QUAD_TICK_DIV)
  ) u_quad_tick (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tick_o(quad_tick)
  );

  // Slow pole keeps short self-test spikes from tripping the flag
  gdtr_lpf #(
    .SHIFT(ST_LPF_SHIFT)
  ) u_st_lpf (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .en_i(st_tick),
    .din_i(raw_selftest_i),
    .dout_o(st_filt)
  );

  gdtr_lpf #(
    .SHIFT(QUAD_LPF_SHIFT)
  ) u_quad_lpf (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .en_i(st_tick),
    .din_i(quad_error_i),
    .dout_o(quad_filt)
  );

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      raw_st_reg <= VALUE_RST;
    end else if (st_tick) begin
      raw_st_reg <= raw_selftest_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quad_reg <= VALUE_RST;
    end else if (quad_tick) begin
      quad_reg <= quad_filt;
    end
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1_reg <= 3'h2;
      pin_s2_reg <= 3'h2;
      pin_prev_reg <= 3'h2;
      fault_s1_reg <= 10'h000;
      fault_s2_reg <= 10'h000;
    end else begin
      pin_s1_reg <= '{sclk: sclk_i, cs_n: cs_n_i, mosi: mosi_i};
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
      fault_s1_reg <= fault_cond_i;
      fault_s2_reg <= fault_s1_reg;
    end
  end

  assign sclk_rise = pin_s2_reg.sclk & ~pin_prev_reg.sclk;
  assign sclk_fall = ~pin_s2_reg.sclk & pin_prev_reg.sclk;
  assign cs_active = ~pin_s2_reg.cs_n;
  assign frame_start = pin_prev_reg.cs_n & ~pin_s2_reg.cs_n;
  assign frame_end = ~pin_prev_reg.cs_n & pin_s2_reg.cs_n;

  // ************************************************************
  // Frame sequencing
  // ************************************************************
  assign cmd_done = (frame_reg == FR_CMD) & cs_active & sclk_rise & (bit_cnt_reg == CMD_LAST_BIT);
  assign cmd_word = {shift_in_reg[6:0], pin_s2_reg.mosi};

  always_comb begin
    frame_next = frame_reg;
    case (frame_reg)
      FR_IDLE: begin
        if (frame_start) begin
          frame_next = FR_CMD;
        end
      end
      FR_CMD: begin
        if (frame_end) begin
          frame_next = FR_IDLE;
        end else if (cmd_done) begin
          frame_next = FR_DATA;
        end
      end
      FR_DATA: begin
        if (frame_end) begin
          frame_next = FR_IDLE;
        end
      end
      default: begin
        frame_next = FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_reg <= FR_IDLE;
      bit_cnt_reg <= 6'h00;
      shift_in_reg <= 32'h0;
    end else begin
      frame_reg <= frame_next;
      if (frame_start) begin
        bit_cnt_reg <= 6'h00;
      end else if (cs_active && sclk_rise) begin
        shift_in_reg <= {shift_in_reg[30:0], pin_s2_reg.mosi};
        bit_cnt_reg <= (bit_cnt_reg == 6'h3f) ? bit_cnt_reg : bit_cnt_reg + 6'h01;
      end
    end
  end

  // ************************************************************
  // Read decode
  // ************************************************************
  function automatic logic [7:0] reg_byte(input logic [5:0] a);
    case (a)
      ADDR_RAW_ST_HI: reg_byte = raw_st_reg[15:8];
      ADDR_RAW_ST_LO: reg_byte = raw_st_reg[7:0];
      ADDR_QUAD_HI: reg_byte = quad_reg[15:8];
      ADDR_QUAD_LO: reg_byte = quad_reg[7:0];
      ADDR_FAULT_HI: reg_byte = flags_reg[15:8];
      ADDR_FAULT_LO: reg_byte = flags_reg[7:0];
      ADDR_PART_HI: reg_byte = PART_VERSION[15:8];
      ADDR_PART_LO: reg_byte = PART_VERSION[7:0];
      ADDR_SERIAL_3: reg_byte = SERIAL_NUMBER[31:24];
      ADDR_SERIAL_2: reg_byte = SERIAL_NUMBER[23:16];
      ADDR_SERIAL_1: reg_byte = SERIAL_NUMBER[15:8];
      ADDR_SERIAL_0: reg_byte = SERIAL_NUMBER[7:0];
      ADDR_TRIM_HI: reg_byte = {6'h00, trim_reg[9:8]};
      ADDR_TRIM_LO: reg_byte = trim_reg[7:0];
      default: reg_byte = 8'h00;
    endcase
  endfunction

  // Addressed byte first, then its neighbour
  // Procedural, so a register change inside reg_byte reaches the pair too
  always_comb begin
    read_pair = {reg_byte(cmd_word.addr), reg_byte(6'(cmd_word.addr + 6'h01))};
    case (cmd_word.op)
      OP_READ: resp_next = {read_pair, 8'h00};
      OP_SENSOR: resp_next = {rate_trim_reg, flags_reg[7:0]};
      default: resp_next = 24'h0;
    endcase
  end

  // ************************************************************
  // Serial answer
  // ************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      resp_reg <= 24'h0;
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else begin
      miso_oe_reg <= cs_active;
      if (frame_end || frame_start) begin
        miso_reg <= 1'b0;
      end else if (cmd_done) begin
        resp_reg <= resp_next;
      end else if ((frame_reg == FR_DATA) && sclk_fall) begin
        miso_reg <= resp_reg[23];
        resp_reg <= {resp_reg[22:0], 1'b0};
      end
    end
  end

  assign miso_o = miso_reg;
  assign miso_oe_o = miso_oe_reg;

  // ************************************************************
  // Fault flags
  // ************************************************************
  // Compare uses the filtered value only, never the raw one
  assign st_fault = ($signed(st_filt) < ST_LIMIT_LO) | ($signed(st_filt) > ST_LIMIT_HI);

  assign cond_vec = {4'h0,
                     fault_s2_reg.fail,
                     fault_s2_reg.drive_level_fault,
                     fault_s2_reg.supply_high_fault,
                     fault_s2_reg.supply_low_fault,
                     fault_s2_reg.pll_fault,
                     fault_s2_reg.q_fault,
                     fault_s2_reg.stored_memory_fault,
                     fault_s2_reg.por_fault,
                     fault_s2_reg.supply_fault,
                     st_fault,
                     fault_s2_reg.self_check_fault,
                     1'b0};

  assign fault_clear = cmd_done & ((cmd_word.op == OP_SENSOR) |
                       ((cmd_word.op == OP_READ) & (cmd_word.addr[5:1] == ADDR_FAULT_HI[5:1])));

  // A standing condition wins over the clear in the same cycle
  assign flags_next = (flags_reg & ~{16{fault_clear}}) | cond_vec;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_reg <= FAULT_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign fault_flags_o = flags_reg;

  // ************************************************************
  // Null trim
  // ************************************************************
  // Write lands only after a full frame, so a cut frame changes nothing
  assign trim_write = frame_end & (frame_reg == FR_DATA) & (bit_cnt_reg == FRAME_BITS) &
                      (shift_in_reg[31:30] == OP_WRITE) & (shift_in_reg[29:24] == ADDR_TRIM_HI);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trim_reg <= TRIM_RST;
    end else if (trim_write) begin
      trim_reg <= shift_in_reg[WDATA_LSB +: TRIM_BITS];
    end
  end

  // No saturation; rate inputs near full scale can wrap
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rate_trim_reg <= VALUE_RST;
    end else begin
      rate_trim_reg <= rate_i + {{6{trim_reg[9]}}, trim_reg};
    end
  end

  assign rate_trimmed_o = rate_trim_reg;

endmodule // gdtr_regs

// ==== testbench/gdtr_regs_asserts.sv ====
// Purpose: Port-level checks of the register bank
// Assumes: Sees only the top module's ports
// Notes: Flag bits: fail 11, drive 10, supply high 9, self check 1
module gdtr_regs_asserts
  import gdtr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic [15:0] rate_i,
  input wire logic [15:0] raw_selftest_i,
  input wire logic [15:0] quad_error_i,
  input wire gdtr_fault_in_t fault_cond_i,
  input wire logic [15:0] rate_trimmed_o,
  input wire logic [15:0] fault_flags_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_set; fault_cond_i.fail |-> ##[1:5] fault_flags_o[11]; endproperty
  a_set: assert property (p_set) else $error("fail flag late");
  property p_unused; fault_flags_o[15:12] == 4'h0 && !fault_flags_o[0]; endproperty
  a_unused: assert property (p_unused) else $error("unused flag bit set");
  // Quiet link for 8 clk means no clear can be in flight
  property p_hold;
    cs_n_i [*8] |-> (fault_flags_o & $past(fault_flags_o)) == $past(fault_flags_o);
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without transfer");
  property p_oe_on; $fell(cs_n_i) |-> ##[2:4] miso_oe_o; endproperty
  a_oe_on: assert property (p_oe_on) else $error("answer driver late");
  property p_idle; cs_n_i [*5] |-> !miso_oe_o && !miso_o; endproperty
  a_idle: assert property (p_idle) else $error("answer line busy when idle");
  property p_trim;
    cs_n_i [*8] ##0 $past(reset_n_i, 2) |->
      (rate_trimmed_o - $past(rate_i)) == ($past(rate_trimmed_o) - $past(rate_i, 2));
  endproperty
  a_trim: assert property (p_trim) else $error("trim offset changed");
  property p_persist; fault_cond_i.drive_level_fault [*5] |-> fault_flags_o[10]; endproperty
  a_persist: assert property (p_persist) else $error("persisting flag lost");
  property p_cause;
    $rose(fault_flags_o[1]) |->
      $past(fault_cond_i.self_check_fault, 2) || $past(fault_cond_i.self_check_fault, 3) ||
      $past(fault_cond_i.self_check_fault, 4);
  endproperty
  a_cause: assert property (p_cause) else $error("flag set without cause");
endmodule // gdtr_regs_asserts

bind gdtr_regs gdtr_regs_asserts u_gdtr_regs_asserts (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .sclk_i(sclk_i), .cs_n_i(cs_n_i), .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
  .rate_i(rate_i), .raw_selftest_i(raw_selftest_i), .quad_error_i(quad_error_i),
  .fault_cond_i(fault_cond_i), .rate_trimmed_o(rate_trimmed_o), .fault_flags_o(fault_flags_o));

// ==== testbench/gdtr_host_model.sv ====
// Purpose: Host serial master, one 32-bit frame per call
// Assumes: Called from the bench; 320 ns serial clock
// Notes: Clock stands still between frames
module gdtr_host_model
  import gdtr_pkg::*;
(
  input wire logic clk_i,
  input wire logic miso_i,
  output gdtr_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Frame
  // ********************
  initial begin
    pins_o = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
  end
  // Even addresses only serial as two reads
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    @(negedge clk_i);
    pins_o.cs_n = 1'b0;
    #160;
    for (int i = 31; i >= 0; i--) begin
      pins_o.mosi = tx[i];
      #160 pins_o.sclk = 1'b1;
      rx[i] = miso_i;
      #160 pins_o.sclk = 1'b0;
    end
    #160 pins_o.cs_n = 1'b1;
    // Released line shows no stale bit
    pins_o.mosi = ~pins_o.mosi;
    #400;
  endtask
endmodule // gdtr_host_model

// ==== testbench/gdtr_regs_tb.sv ====
// Purpose: Self-checking bench for the register bank
// Assumes: Short tick dividers for run time
// Notes: Filter results checked loosely, fraction bits may truncate
module gdtr_regs_tb
  import gdtr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Harness
  // ********************
  localparam logic [15:0] PV = 16'h0b07; // Arbitrary value
  localparam logic [31:0] SERIAL_VAL = 32'hc3a5_9e11; // Arbitrary value
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  gdtr_pins_t pins;
  logic miso;
  logic miso_oe;
  logic [15:0] rate = 16'h8123;
  logic [15:0] raw = 16'h0000;
  logic [15:0] quad = 16'h0000;
  gdtr_fault_in_t cond = '0;
  logic [15:0] trimmed;
  logic [15:0] flags;
  logic [31:0] rx;
  int err_total = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  gdtr_host_model u_gdtr_host_model (.clk_i(clk), .miso_i(miso), .pins_o(pins));
  gdtr_regs #(.ST_TICK_DIV(50), .QUAD_TICK_DIV(200), .PART_VERSION(PV), .SERIAL_NUMBER(SERIAL_VAL)) u_gdtr_regs (
    .clk_i(clk), .reset_n_i(reset_n), .sclk_i(pins.sclk), .cs_n_i(pins.cs_n), .mosi_i(pins.mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .rate_i(rate), .raw_selftest_i(raw), .quad_error_i(quad),
    .fault_cond_i(cond), .rate_trimmed_o(trimmed), .fault_flags_o(flags));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd(input logic [5:0] a);
    u_gdtr_host_model.frame({OP_READ, a, 24'h0}, rx);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    u_gdtr_host_model.frame({OP_WRITE, a, d, 8'h00}, rx);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_ids;
    rd(ADDR_PART_HI); chk(rx[23:8], PV);
    rd(ADDR_SERIAL_3); chk(rx[23:8], SERIAL_VAL[31:16]);
    rd(ADDR_SERIAL_1); chk(rx[23:8], SERIAL_VAL[15:0]);
    rd(6'h14); chk(rx[23:0], 24'h0);
    wr(ADDR_PART_HI, 16'hffff); rd(ADDR_PART_HI); chk(rx[23:8], PV);
    $display("test ids done");
  endtask
  task automatic t_trim;
    chk(trimmed, 16'h8123);
    // Upper data bits must be dropped, sign of bit 9 kept
    wr(ADDR_TRIM_HI, 16'hfe05); rd(ADDR_TRIM_HI); chk(rx[23:8], 16'h0205);
    idle(2); chk(trimmed, 16'h7f28);
    // Offset must follow a moving rate input, not just one value
    rate = 16'h0100; idle(2); chk(trimmed, 16'hff05);
    rate = 16'h8123; idle(2); chk(trimmed, 16'h7f28);
    $display("test trim done");
  endtask
  task automatic t_fault;
    cond.fail = 1'b1; idle(4); cond.fail = 1'b0; idle(10);
    chk(flags, 16'h0800);
    rd(ADDR_FAULT_HI); chk(rx[23:8], 16'h0800);
    rd(ADDR_FAULT_HI); chk(rx[23:8], 16'h0000);
    cond.supply_low_fault = 1'b1; cond.drive_level_fault = 1'b1; idle(10);
    rd(ADDR_FAULT_HI); chk(rx[23:8], 16'h0500);
    rd(ADDR_FAULT_HI); chk(rx[23:8], 16'h0500);
    cond.supply_low_fault = 1'b0; cond.drive_level_fault = 1'b0;
    cond.self_check_fault = 1'b1; idle(5); cond.self_check_fault = 1'b0;
    cond.q_fault = 1'b1; idle(5); cond.q_fault = 1'b0; idle(10);
    rd(ADDR_FAULT_HI); chk(rx[23:8], 16'h0542);
    cond.q_fault = 1'b1; idle(5); cond.q_fault = 1'b0; idle(10);
    u_gdtr_host_model.frame({OP_SENSOR, 30'h0}, rx); chk(rx[23:0], {16'h7f28, 8'h40});
    rd(ADDR_FAULT_HI); chk(rx[23:8], 16'h0000);
    $display("test fault done");
  endtask
  task automatic t_raw;
    // Raw above the limit at once; the flag must wait for the slow filter
    raw = 16'h0400; quad = 16'h0200; idle(120);
    rd(ADDR_RAW_ST_HI); chk(rx[23:8], 16'h0400);
    chk(flags[2], 1'b0);
    idle(15000); chk(flags[2], 1'b1);
    rd(ADDR_QUAD_HI); chk(32'(rx[23:8] inside {16'h01ff, 16'h0200}), 32'h1);
    $display("test raw done");
  endtask
  initial begin
    idle(10); reset_n = 1'b1; idle(4);
    t_ids;
    t_trim;
    t_fault;
    t_raw;
    results;
  end
  initial begin
    #2_000_000;
    err_total++;
    results;
  end
endmodule // gdtr_regs_tb
